//--- bank_conflict_ready_arbiter_tb.sv
// self-checking bench for the ready arbiter
// assumes short parameters for init, sequence, gap and grace
`timescale 1ns/100ps
module bank_conflict_ready_arbiter_tb;
    import bcra_pkg::*;
    logic                 CLK = 0, NRST = 0, camp = 0, idle = 0;
    logic                 sel, READY, HK_ACCESS;
    logic [BANK_BITS-1:0] addr, HK_BANK;
    int                   error_cnt = 0, n_checks = 0, n, hk_n = 0, hk_prev;
    logic [BANK_BITS-1:0] stall_bank;
    initial forever #2.5 CLK = ~CLK;
    always @(posedge CLK) hk_n <= hk_n + int'(HK_ACCESS === 1'b1);
    bcra_arbiter #(.INIT_LEN(4), .SEQ_LEN(4), .SEQ_GAP(8), .GRACE_LEN(4)) uut (
        .CLK(CLK), .NRST(NRST), .USER_SEL(sel), .USER_ADDR_LO(addr),
        .READY(READY), .HK_ACCESS(HK_ACCESS), .HK_BANK(HK_BANK));
    bcra_ctrl_model ctrl (.CLK(CLK), .camp(camp), .idle(idle), .READY(READY),
        .HK_BANK(HK_BANK), .sel(sel), .addr(addr));
    function automatic int stall_min(int seq_len, int grace_len);
        return seq_len + grace_len;
    endfunction
    // two synchroniser edges, then the init count
    function automatic int init_edges(int init_len);
        return init_len + 2;
    endfunction
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_ready(logic lvl, int lim);
        n = 0;
        while (READY !== lvl && n < lim) begin
            @(posedge CLK);
            #1 n++;
        end
        if (READY !== lvl) begin
            error_cnt++;
            $display("[ERR] ready_wait exp %b seen %b", lvl, READY);
            conclude();
        end
    endtask
    initial begin
        n = $urandom(32'hbcf0_c062);
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        #1 chk("ready_init", READY, 8'h00);
        wait_ready(1'b1, 20);
        repeat (600) begin
            @(posedge CLK);
            idle <= ($urandom % 4) == 0;
            #1 chk("ready_walk", READY, 8'h01);
        end
        chk("hk_background", hk_n > 10, 8'h01);
        @(posedge CLK);
        camp <= 1'b1;
        #1 wait_ready(1'b0, 100);
        chk("stall_len", n >= stall_min(4, 4), 8'h01);
        hk_prev    = hk_n;
        stall_bank = HK_BANK;
        wait_ready(1'b1, 18);
        chk("hk_done", hk_n > hk_prev, 8'h01);
        chk("hk_resume", HK_BANK, BANK_BITS'(stall_bank + 7'h01));
        @(posedge CLK);
        camp <= 1'b0;
        repeat (20) @(posedge CLK);
        NRST <= 1'b0;
        #1 chk("ready_rst", READY, 8'h00);
        repeat (2) @(posedge CLK);
        NRST <= 1'b1;
        wait_ready(1'b1, 20);
        chk("ready_rise", 8'(n), 8'(init_edges(4)));
        conclude();
    end
endmodule // bank_conflict_ready_arbiter_tb
bind bcra_arbiter bcra_arbiter_assertions #(.INIT_LEN(INIT_LEN), .SEQ_LEN(SEQ_LEN),
    .GRACE_LEN(GRACE_LEN)) chk_i (.CLK(CLK), .NRST(NRST), .USER_SEL(USER_SEL),
    .USER_ADDR_LO(USER_ADDR_LO), .READY(READY), .HK_ACCESS(HK_ACCESS), .HK_BANK(HK_BANK));

//--- bcra_arbiter.sv
// housekeeping scheduler and ready generator for a banked sram
// assumes synchronous user pins; address low bits pick the bank
`timescale 1ns/100ps
module bcra_arbiter
    import bcra_pkg::*;
#(
    parameter int unsigned INIT_LEN   = INIT_CYCLES,
    parameter int unsigned SEQ_LEN    = SEQ_CYCLES,
    parameter int unsigned SEQ_GAP    = SEQ_INTERVAL,
    parameter int unsigned GRACE_LEN  = GRACE_CYCLES
)(
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 NRST,
    // user access
    input  wire logic                 USER_SEL,
    input  wire logic [BANK_BITS-1:0] USER_ADDR_LO,
    // status
    output logic                      READY,
    output logic                      HK_ACCESS,
    output logic [BANK_BITS-1:0]      HK_BANK
);
    ////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire logic rst_n = rst_sync_r;

    ////////////////////////////////////////////////////////////////////
    // conflict check
    bcra_user_s user;
    bcra_hk_s   hk;
    logic       conflict;
    logic       hk_grant;
    bcra_state_e  state_r, state_nxt;
    logic [CNT_BITS-1:0] cnt_r, cnt_nxt;
    logic [CNT_BITS-1:0] gap_r, gap_nxt;
    bcra_bank_t bank_r, bank_nxt;
    logic ready_r, ready_nxt;
    logic hk_acc_r, hk_acc_nxt;

    always_comb begin
        user.sel  = USER_SEL;
        user.bank = USER_ADDR_LO;
        hk.req    = (state_r == HK_SEQ) || (state_r == HK_GRACE)
                    || (state_r == HK_STALL);
        hk.bank   = bank_r;
    end

    bcra_conflict u_conflict (
        .user     (user),
        .hk       (hk),
        .conflict (conflict),
        .hk_grant (hk_grant)
    );

    ////////////////////////////////////////////////////////////////////
    // housekeeping state machine
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        gap_nxt    = gap_r;
        bank_nxt   = bank_r;
        ready_nxt  = ready_r;
        hk_acc_nxt = 1'b0;
        case (state_r)
            HK_INIT: begin
                ready_nxt = 1'b0;
                if (cnt_r == CNT_BITS'(INIT_LEN - 1)) begin
                    state_nxt = HK_IDLE;
                    cnt_nxt   = '0;
                    ready_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            HK_IDLE: begin
                if (gap_r == CNT_BITS'(SEQ_GAP - 1)) begin
                    gap_nxt   = '0;
                    cnt_nxt   = '0;
                    state_nxt = HK_SEQ;
                    // prefer a bank the user is not on
                    bank_nxt  = (USER_SEL && USER_ADDR_LO == bank_r)
                                ? bank_r + 1'b1 : bank_r;
                end else begin
                    gap_nxt = gap_r + 1'b1;
                end
            end
            HK_SEQ: begin
                if (hk_grant) begin
                    hk_acc_nxt = 1'b1;
                    state_nxt  = HK_DONE;
                end else if (cnt_r == CNT_BITS'(SEQ_LEN - 1)) begin
                    state_nxt = HK_GRACE;
                    cnt_nxt   = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            HK_GRACE: begin
                if (hk_grant) begin
                    hk_acc_nxt = 1'b1;
                    state_nxt  = HK_DONE;
                end else if (cnt_r == CNT_BITS'(GRACE_LEN - 1)) begin
                    ready_nxt = 1'b0;
                    state_nxt = HK_STALL;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            HK_STALL: begin
                // no timeout and no new sequence while stalled
                if (hk_grant) begin
                    hk_acc_nxt = 1'b1;
                    state_nxt  = HK_DONE;
                end
            end
            HK_DONE: begin
                ready_nxt = 1'b1;
                bank_nxt  = bank_r + 1'b1;
                gap_nxt   = '0;
                cnt_nxt   = '0;
                state_nxt = HK_IDLE;
            end
            default: begin
                state_nxt = HK_INIT;
                cnt_nxt   = '0;
                ready_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= HK_INIT;
            cnt_r    <= '0;
            gap_r    <= '0;
            bank_r   <= '0;
            ready_r  <= 1'b0;
            hk_acc_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            gap_r    <= gap_nxt;
            bank_r   <= bank_nxt;
            ready_r  <= ready_nxt;
            hk_acc_r <= hk_acc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        READY     = ready_r;
        HK_ACCESS = hk_acc_r;
        HK_BANK   = bank_r;
    end
endmodule // bcra_arbiter

//--- bcra_arbiter_assertions.sv
// checker for the ready arbiter, watching its top ports only
// assumes one clock domain and the bench bind
`timescale 1ns/100ps
module bcra_arbiter_assertions
    import bcra_pkg::*;
#(
    parameter int unsigned INIT_LEN  = 4,
    parameter int unsigned SEQ_LEN   = 4,
    parameter int unsigned GRACE_LEN = 4
)(
    // clock and reset
    input wire logic                 CLK,
    input wire logic                 NRST,
    // watched pins
    input wire logic                 USER_SEL,
    input wire logic [BANK_BITS-1:0] USER_ADDR_LO,
    input wire logic                 READY,
    input wire logic                 HK_ACCESS,
    input wire logic [BANK_BITS-1:0] HK_BANK
);
    logic        conf;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // run length of user sitting on the housekeeping bank
    always_comb begin
        conf    = USER_SEL && USER_ADDR_LO == HK_BANK;
        cnt_nxt = conf ? cnt_r + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) cnt_r <= 16'h0000;
        else cnt_r <= cnt_nxt;
    end
    fall_cause_a: assert property ($fell(READY) |-> $past(conf))
        else $error("ready fell without a bank conflict");
    fall_count_a: assert property ($fell(READY) |-> cnt_r >= SEQ_LEN + GRACE_LEN)
        else $error("ready fell before the grace period ran out");
    grant_free_a: assert property (HK_ACCESS |-> !$past(conf))
        else $error("housekeeping granted during a conflict");
    pulse_one_a: assert property (HK_ACCESS |=> !HK_ACCESS)
        else $error("housekeeping pulse longer than one cycle");
    ready_back_a: assert property (!READY && HK_ACCESS |=> READY)
        else $error("ready not restored after the pending access");
    init_low_a: assert property ($rose(NRST) |-> !READY [*4])
        else $error("ready high during reset activity");
    stall_hold_a: assert property (!READY && conf && cnt_r > 16'd8 |=> !READY)
        else $error("ready rose while the conflict persists");
    bank_hold_a: assert property (!READY && conf |=> $stable(HK_BANK))
        else $error("housekeeping bank moved during a stall");
endmodule // bcra_arbiter_assertions

//--- bcra_conflict.sv
// bank conflict detector: user access versus housekeeping bank
// assumes both inputs sampled on the same clock cycle
`timescale 1ns/100ps
module bcra_conflict
    import bcra_pkg::*;
(
    // access pair
    input  wire bcra_user_s user,
    input  wire bcra_hk_s   hk,
    // result
    output logic            conflict,
    output logic            hk_grant
);
    always_comb begin
        conflict = user.sel && hk.req && (user.bank == hk.bank);
        hk_grant = hk.req && !conflict;
    end
endmodule // bcra_conflict

//--- bcra_ctrl_model.sv
// controller model: walks banks, or camps on the housekeeping bank
// assumes the bench drives camp and idle at the rising edge
`timescale 1ns/100ps
module bcra_ctrl_model
    import bcra_pkg::*;
(
    // control and device status
    input  wire logic                 CLK,
    input  wire logic                 camp,
    input  wire logic                 idle,
    input  wire logic                 READY,
    input  wire logic [BANK_BITS-1:0] HK_BANK,
    // user pins
    output logic                      sel,
    output logic [BANK_BITS-1:0]      addr
);
    logic [BANK_BITS-1:0] walk_r = '0;
    logic                 sel_r  = 1'b0;
    int                   low_n  = 0;
    always @(posedge CLK) begin
        low_n  <= READY ? 0 : low_n + 1;
        sel_r  <= camp ? low_n < 5 : !idle;
        walk_r <= walk_r + 7'h01;
    end
    // camping follows the housekeeping bank with no lag, else the address walks up one bank every cycle
    always_comb begin
        sel  = sel_r;
        addr = camp ? HK_BANK : walk_r;
    end
endmodule // bcra_ctrl_model

//--- bcra_pkg.sv
// package for the bank conflict ready arbiter: constants, types
// assumes one device clock; user side is an external sram controller
package bcra_pkg;
    localparam int unsigned BANK_BITS      = 7;
    localparam int unsigned NUM_BANKS      = 128;
    localparam int unsigned GRACE_CYCLES   = 64;
    localparam int unsigned RELEASE_CYCLES = 16;
    localparam int unsigned INIT_CYCLES    = 128;
    localparam int unsigned SEQ_CYCLES     = 32;
    localparam int unsigned SEQ_INTERVAL   = 256;
    localparam int unsigned CNT_BITS       = 16;

    typedef logic [BANK_BITS-1:0] bcra_bank_t;

    // one user access as seen on the pins
    typedef struct packed {
        logic       sel;
        bcra_bank_t bank;
    } bcra_user_s;

    // housekeeping request toward the arbiter
    typedef struct packed {
        logic       req;
        bcra_bank_t bank;
    } bcra_hk_s;

    typedef enum logic [5:0] {
        HK_INIT  = 6'b00_0001,
        HK_IDLE  = 6'b00_0010,
        HK_SEQ   = 6'b00_0100,
        HK_GRACE = 6'b00_1000,
        HK_STALL = 6'b01_0000,
        HK_DONE  = 6'b10_0000
    } bcra_state_e;
endpackage
